// ==== sar_adc_params.svh ====
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH
// register byte offsets on the apb window
`define ADC_SC_OFFSET     12'h03c
`define ADC_RES_OFFSET    12'h040
`define ADC_CLK_OFFSET    12'h044
// reset values
`define ADC_SC_RESET      8'h1f
`define ADC_RES_RESET     8'h00
`define ADC_CLK_RESET     8'h00
// clock config field positions
`define ADC_DIV_MSB       7
`define ADC_DIV_LSB       5
`define ADC_ICLK_BIT      4
// status/control field positions
`define ADC_FLAG_BIT      7
`define ADC_IEN_BIT       6
// channel codes
`define ADC_CH_LAST_PIN   5'h05
`define ADC_CH_REFH       5'h1d
`define ADC_CH_REFL       5'h1e
`define ADC_CH_PWROFF     5'h1f
// conversion timing in divided converter clocks
`define ADC_LAST_STEP     4'hf
// divider terminal counts per prescale code
`define ADC_DIV1_LAST     4'h0
`define ADC_DIV2_LAST     4'h1
`define ADC_DIV4_LAST     4'h3
`define ADC_DIV8_LAST     4'h7
`define ADC_DIV16_LAST    4'hf
// result constants
`define ADC_ZERO_CODE     8'h00
`endif

// ==== sar_adc_pkg.sv ====
package sar_adc_pkg;
  // converter sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } conv_state_t;
  // status/control register image
  typedef struct packed {
    logic       doneFlagDmaSelect;
    logic       convIrqEnable;
    logic       continuousMode;
    logic [4:0] channelSelect;
  } status_ctrl_t;
  // clock configuration register image
  typedef struct packed {
    logic [2:0] clockPrescale;
    logic       inputClockSelect;
    logic [3:0] spare;
  } clock_cfg_t;
endpackage

// ==== sar_adc_control.sv ====
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_params.svh"
module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int N_PINS = 6                   // port pins shared with the mux
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              oscillatorRefClock,
  input  wire logic              compAbove,
  input  wire logic              stopMode,
  output logic                   cpuIrq,
  output logic                   dmaReq,
  output logic [4:0]             channelSelect,
  output logic                   adcPowerOn,
  output logic [7:0]             dacCode,
  output logic [N_PINS-1:0]      pinAnalogSel
);

////////////////////////////////////////////////////////////////////////////
// declarations
logic [1:0]   rstSync_q;                     // reset release pipeline
wire  logic   rstN;                          // synchronised reset
logic [2:0]   oscSync_q;                     // oscillator sampler
logic [1:0]   cmpSync_q;                     // comparator sampler
status_ctrl_t ctrl_q;                        // status/control register
status_ctrl_t ctrl_d;                        // its next value
clock_cfg_t   clkCfg_q;                      // clock config register
logic [7:0]   result_q;                      // result register
logic         pready_q;                      // access phase answered
logic [31:0]  prdata_q;                      // captured read data
logic         pslverr_q;                     // unmapped address answer
conv_state_t  state_q;                       // sequencer state
logic [3:0]   step_q;                        // converter clock index
logic [7:0]   trial_q;                       // successive approx code
logic [3:0]   divCnt_q;                      // prescale counter
logic [3:0]   divLast;                       // prescale terminal count
logic         srcTick;                       // one selected input clock
logic         adcTick;                       // one divided clock
logic         firstSeen_q;                   // continuous flag gate
logic         resume_q;                      // restart after stop
logic         reqPend_q;                     // pending completion request
logic         cpuIrq_q;                      // cpu request flop
logic         dmaReq_q;                      // dma request flop
logic         powerOn_q;                     // converter powered
logic [N_PINS-1:0] pinSel_q;                 // pin override flops
logic         access;                        // apb access phase
logic         xferDone;                      // transfer completes now
logic         hitSc;                         // address decode
logic         hitRes;
logic         hitClk;
logic         mapped;
logic         scWrite;                       // control register written
logic         resRead;                       // result register read
logic         clkWrite;                      // clock config written
logic         reserved;                      // channel code unassigned
logic         convEnd;                       // last step finishing
logic         startNow;                      // begin a fresh conversion
logic [2:0]   bitIdx;                        // bit under trial
logic [7:0]   sarNext;                       // trial code after step
logic [7:0]   convResult;                    // value loaded at the end
logic [31:0]  readMux;                       // register read selection
logic         flagMaySet;                    // done flag may rise

////////////////////////////////////////////////////////////////////////////
// reset synchroniser: release passes two flops
always_ff @(posedge mclk or negedge arst_n) begin
  if (!arst_n) begin
    rstSync_q <= 2'b00;
  end else begin
    rstSync_q <= {rstSync_q[0], 1'b1};
  end
end
assign rstN = rstSync_q[1];

////////////////////////////////////////////////////////////////////////////
// input samplers: stage 0 feeds stage 1 only
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    oscSync_q <= 3'h0;
    cmpSync_q <= 2'h0;
  end else begin
    oscSync_q <= {oscSync_q[1:0], oscillatorRefClock};
    cmpSync_q <= {cmpSync_q[0], compAbove};
  end
end

////////////////////////////////////////////////////////////////////////////
// apb decode; one wait state so read data comes from a flop
assign access   = psel & penable;
assign xferDone = access & pready_q;
assign hitSc    = (paddr == `ADC_SC_OFFSET);
assign hitRes   = (paddr == `ADC_RES_OFFSET);
assign hitClk   = (paddr == `ADC_CLK_OFFSET);
assign mapped   = hitSc | hitRes | hitClk;
assign scWrite  = xferDone & pwrite & hitSc;
assign resRead  = xferDone & ~pwrite & hitRes;
assign clkWrite = xferDone & pwrite & hitClk;

// read selection; upper bits read zero
always_comb begin
  readMux = 32'h0;
  if (hitSc) begin
    readMux = {24'h0, ctrl_q};
  end else if (hitRes) begin
    readMux = {24'h0, result_q};
  end else if (hitClk) begin
    readMux = {24'h0, clkCfg_q};
  end
end

// apb answer flops
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    pready_q  <= 1'b0;
    prdata_q  <= 32'h0;
    pslverr_q <= 1'b0;
  end else begin
    pready_q  <= access & ~pready_q;
    pslverr_q <= access & ~pready_q & ~mapped;
    if (access & ~pready_q & ~pwrite) begin
      prdata_q <= readMux;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// clock source and prescaler
// oscillator edges are found after sampling, so it must run well
// below mclk/2; the bus clock path ticks every cycle
assign srcTick = clkCfg_q.inputClockSelect ? 1'b1 : (oscSync_q[1] & ~oscSync_q[2]);

// terminal count per prescale code
always_comb begin
  case (clkCfg_q.clockPrescale)
    3'b000:  divLast = `ADC_DIV1_LAST;
    3'b001:  divLast = `ADC_DIV2_LAST;
    3'b010:  divLast = `ADC_DIV4_LAST;
    3'b011:  divLast = `ADC_DIV8_LAST;
    default: divLast = `ADC_DIV16_LAST;
  endcase
end
assign adcTick = srcTick & (divCnt_q >= divLast);

// divider restarts with each conversion for a full first period
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    divCnt_q <= 4'h0;
  end else if (startNow) begin
    divCnt_q <= 4'h0;
  end else if (adcTick) begin
    divCnt_q <= 4'h0;
  end else if (srcTick) begin
    divCnt_q <= divCnt_q + 4'h1;
  end
end

// clock config register
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    clkCfg_q <= `ADC_CLK_RESET;
  end else if (clkWrite) begin
    clkCfg_q <= clock_cfg_t'(pwdata[7:0]);
  end
end

////////////////////////////////////////////////////////////////////////////
// sequencer control terms
// a write never completes a conversion in the same cycle
assign convEnd = (state_q == ST_CONV) & adcTick & (step_q == `ADC_LAST_STEP)
               & ~stopMode & ~scWrite;
// a write restarts unless powered off; stop exit resumes
assign startNow = ~stopMode & ((scWrite & (pwdata[4:0] != `ADC_CH_PWROFF))
                | (resume_q & ~scWrite));

// unassigned codes between the pins and the references
assign reserved = (ctrl_q.channelSelect > `ADC_CH_LAST_PIN)
                & (ctrl_q.channelSelect < `ADC_CH_REFH);

// even steps set the trial bit, odd steps keep or drop it
assign bitIdx = 3'h7 - step_q[3:1];
always_comb begin
  sarNext = trial_q;
  if (step_q[0]) begin
    sarNext[bitIdx] = cmpSync_q[1];
  end else begin
    sarNext[bitIdx] = 1'b1;
  end
end
assign convResult = reserved ? `ADC_ZERO_CODE : sarNext;

////////////////////////////////////////////////////////////////////////////
// sequencer: 16 converter clocks, two per result bit
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    state_q <= ST_IDLE;
    step_q  <= 4'h0;
    trial_q <= 8'h0;
  end else if (stopMode) begin
    state_q <= ST_IDLE;
    step_q  <= 4'h0;
  end else if (startNow) begin
    state_q <= ST_CONV;
    step_q  <= 4'h0;
    trial_q <= 8'h0;
  end else if (scWrite) begin
    state_q <= ST_IDLE;
  end else begin
    case (state_q)
      ST_IDLE: begin
        step_q <= 4'h0;
      end
      ST_CONV: begin
        if (adcTick) begin
          step_q  <= step_q + 4'h1;
          trial_q <= sarNext;
          if (step_q == `ADC_LAST_STEP) begin
            // wait mode does not stop this loop
            if (ctrl_q.continuousMode) begin
              trial_q <= 8'h0;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_q <= ST_IDLE;
      end
    endcase
  end
end

// remember an interrupted conversion across stop
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    resume_q <= 1'b0;
  end else if (stopMode) begin
    resume_q <= resume_q | (state_q == ST_CONV);
  end else if (startNow | scWrite) begin
    resume_q <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// result register: every completion overwrites it
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    result_q <= `ADC_RES_RESET;
  end else if (convEnd) begin
    result_q <= convResult;
  end
end

////////////////////////////////////////////////////////////////////////////
// status/control register
// continuous mode raises the flag once per control write
assign flagMaySet = ~ctrl_q.continuousMode | ~firstSeen_q;

always_comb begin
  ctrl_d = ctrl_q;
  if (scWrite) begin
    ctrl_d = status_ctrl_t'(pwdata[7:0]);
    // without irq enable bit7 is read only and the write clears it
    ctrl_d.doneFlagDmaSelect = pwdata[`ADC_IEN_BIT] & pwdata[`ADC_FLAG_BIT];
  end else if (!ctrl_q.convIrqEnable) begin
    // completion beats a simultaneous result read
    if (convEnd & flagMaySet) begin
      ctrl_d.doneFlagDmaSelect = 1'b1;
    end else if (resRead) begin
      ctrl_d.doneFlagDmaSelect = 1'b0;
    end
  end
end

// with irq enabled bit7 only holds the routing choice
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    ctrl_q <= `ADC_SC_RESET;
  end else begin
    ctrl_q <= ctrl_d;
  end
end

// first completion since the last control write
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    firstSeen_q <= 1'b0;
  end else if (scWrite) begin
    firstSeen_q <= 1'b0;
  end else if (convEnd) begin
    firstSeen_q <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////
// completion request; a completion beats a same-cycle read
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    reqPend_q <= 1'b0;
  end else if (convEnd & ctrl_q.convIrqEnable) begin
    reqPend_q <= 1'b1;
  end else if (scWrite | resRead) begin
    reqPend_q <= 1'b0;
  end
end

// routing: the dma path has no consumer on this part, so a set
// select silently swallows cpu requests
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    cpuIrq_q <= 1'b0;
    dmaReq_q <= 1'b0;
  end else begin
    cpuIrq_q <= reqPend_q & ctrl_q.convIrqEnable & ~ctrl_q.doneFlagDmaSelect;
    dmaReq_q <= reqPend_q & ctrl_q.convIrqEnable & ctrl_q.doneFlagDmaSelect;
  end
end

////////////////////////////////////////////////////////////////////////////
// analog side: power and port pin override
always_ff @(posedge mclk or negedge rstN) begin
  if (!rstN) begin
    powerOn_q <= 1'b0;
  end else begin
    powerOn_q <= (ctrl_q.channelSelect != `ADC_CH_PWROFF) & ~stopMode;
  end
end

// one override flop per shared pin
genvar gi;
generate
  for (gi = 0; gi < N_PINS; gi++) begin : g_pin
    always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
        pinSel_q[gi] <= 1'b0;
      end else begin
        pinSel_q[gi] <= (ctrl_q.channelSelect == 5'(gi));
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////
// outputs, all from flops
assign pready        = pready_q;
assign prdata        = prdata_q;
assign pslverr       = pslverr_q;
assign cpuIrq        = cpuIrq_q;
assign dmaReq        = dmaReq_q;
assign channelSelect = ctrl_q.channelSelect;
assign adcPowerOn    = powerOn_q;
assign dacCode       = trial_q;
assign pinAnalogSel  = pinSel_q;

endmodule
`default_nettype wire

// ==== sar_adc_control_props.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_params.svh"
// port level checks of the converter control block
module sar_adc_control_props
  import sar_adc_pkg::*;
#(
  parameter int N_PINS = 6
) (
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              stopMode,
  input wire logic              cpuIrq,
  input wire logic              dmaReq,
  input wire logic [4:0]        channelSelect,
  input wire logic              adcPowerOn,
  input wire logic [N_PINS-1:0] pinAnalogSel
);
  logic              scWr;    // status write completes
  logic              scRd;    // status read completes
  logic              resRd;   // result read completes
  logic              ien_q;   // enable bit as last written
  logic              sel_q;   // route bit as last written
  logic [7:0]        expSc_q; // status readback expected before any completion
  logic [N_PINS-1:0] pinExp;  // one-hot pin decode
  assign scWr = psel && penable && pready && pwrite && paddr == `ADC_SC_OFFSET;
  assign scRd = psel && penable && pready && !pwrite && paddr == `ADC_SC_OFFSET;
  assign resRd = psel && penable && pready && !pwrite && paddr == `ADC_RES_OFFSET;
  ////////////////////////////////////////////////////////////////
  // shadow of software writes; the route bit only sticks while enabled
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ien_q <= 1'b0;
      sel_q <= 1'b0;
      expSc_q <= `ADC_SC_RESET;
    end else if (scWr) begin
      ien_q <= pwdata[6];
      sel_q <= pwdata[6] & pwdata[7];
      expSc_q <= {pwdata[6] & pwdata[7], pwdata[6:0]};
    end
  end
  // decode expected on the pin selects, reserved codes pick none
  always_comb begin
    pinExp = '0;
    if (channelSelect < N_PINS) pinExp[channelSelect] = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_cpu_route;
    $rose(cpuIrq) |-> ien_q && !sel_q;
  endproperty
  a_cpu_route: assert property (p_cpu_route)
    else $error("cpu request without enable or with dma route");
  property p_dma_route;
    $rose(dmaReq) |-> ien_q && sel_q;
  endproperty
  a_dma_route: assert property (p_dma_route)
    else $error("dma request without enable and route");
  property p_req_drop;
    scWr || resRd |=> ##1 !cpuIrq && !dmaReq;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("request kept after clearing access");
  property p_power_off;
    channelSelect == 5'h1f |=> !adcPowerOn;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("converter powered with off code");
  property p_stop;
    stopMode |=> !adcPowerOn;
  endproperty
  a_stop: assert property (p_stop)
    else $error("converter powered in stop mode");
  property p_pin_sel;
    $stable(channelSelect) |-> pinAnalogSel == pinExp;
  endproperty
  a_pin_sel: assert property (p_pin_sel)
    else $error("pin select does not match channel");
  property p_unmapped;
    pready |-> pslverr == !(paddr inside {`ADC_SC_OFFSET, `ADC_RES_OFFSET, `ADC_CLK_OFFSET});
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("error response on wrong address");
  property p_sc_read;
    scWr ##[1:4] scRd |-> prdata[7:0] == expSc_q;
  endproperty
  a_sc_read: assert property (p_sc_read)
    else $error("status readback differs from write");
  c_cpu: cover property ($rose(cpuIrq));
  c_dma: cover property ($rose(dmaReq));
  c_stop: cover property ($rose(stopMode));
endmodule
bind sar_adc_control sar_adc_control_props #(.N_PINS(N_PINS)) i_props (
  .mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .stopMode, .cpuIrq, .dmaReq, .channelSelect, .adcPowerOn, .pinAnalogSel
);
`default_nettype wire

// ==== adc_analog_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// analog mux and comparator, ideal and settled at once
module adc_analog_model
  import sar_adc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [4:0] channelSelect,
  input  wire logic [7:0] dacCode,
  input  wire logic       adcPowerOn,
  input  wire logic [7:0] levelShift,
  output logic            compAbove
);
  logic [7:0] level;         // voltage on the selected node
  logic       junk_q = 1'b0; // output of an unpowered comparator
  // pins step apart so each channel yields its own code
  always_comb begin
    level = 8'h5a;  // reserved codes see a floating node
    if (channelSelect < 5'h06) level = 8'h31 + 8'h27 * channelSelect + levelShift;
    if (channelSelect == 5'h1d) level = 8'hff;
    if (channelSelect == 5'h1e) level = 8'h00;
  end
  // powered off the comparator means nothing, so it wanders
  always_ff @(posedge mclk) begin
    junk_q <= ~junk_q;
  end
  assign compAbove = adcPowerOn ? (level >= dacCode) : junk_q;
endmodule
`default_nettype wire

// ==== test_sar_adc_control.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_params.svh"
module test_sar_adc_control
  import sar_adc_pkg::*;
;
  localparam logic [11:0] SC = `ADC_SC_OFFSET;
  localparam logic [11:0] RS = `ADC_RES_OFFSET;
  localparam logic [11:0] CK = `ADC_CLK_OFFSET;
  logic        mclk = 1'b0;
  logic        osc = 1'b0;  // oscillator, phase unrelated to mclk
  logic        arst_n, psel, penable, pwrite, stopMode, rerr;
  logic        pready, pslverr, cpuIrq, dmaReq, adcPowerOn, compAbove;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0]  channelSelect;
  logic [7:0]  dacCode, levelShift;
  logic [5:0]  pinAnalogSel;
  int          nErrors = 0;
  int          testsRun = 0;
  always #4 mclk = ~mclk;
  always #22.5 osc = ~osc;
  sar_adc_control #(.N_PINS(6)) i_dut (
    .mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .oscillatorRefClock(osc), .compAbove, .stopMode, .cpuIrq, .dmaReq, .channelSelect,
    .adcPowerOn, .dacCode, .pinAnalogSel
  );
  adc_analog_model i_model (.mclk, .channelSelect, .dacCode, .adcPowerOn, .levelShift, .compAbove);
  ////////////////////////////////////////////////////////////////
  task automatic finishTest();
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a hung wait counts as a mismatch and ends the run
  task automatic bail();
    nErrors++;
    finishTest();
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) bail();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  // poll the done flag; only valid with the irq enable clear
  task automatic waitFlag();
    int n;
    n = 0;
    do begin
      rd(SC);
      n++;
    end while (rdat[7] !== 1'b1 && n < 200);
    if (rdat[7] !== 1'b1) bail();
  endtask
  task automatic waitReq(output int n);
    n = 0;
    while (!(cpuIrq === 1'b1 || dmaReq === 1'b1) && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) bail();
  endtask
  // ideal comparator gives back the node level as the code
  function automatic logic [7:0] expRes(input logic [4:0] ch);
    if (ch < 5'h06) return 8'h31 + 8'h27 * ch + levelShift;
    return (ch == 5'h1d) ? 8'hff : 8'h00;
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic tReset();
    rd(SC);
    chk("status", rdat, 32'h1f);
    rd(CK);
    chk("clock cfg", rdat, 32'h00);
    chk("power", adcPowerOn, 1'b0);
    wr(RS, 8'hff);
    rd(RS);
    chk("result", rdat, 32'h00);
    rd(12'h048);
    chk("unmapped", rerr, 1'b1);
  endtask
  // bus clock over 8: faster than usual, keeps the run short
  task automatic tChannels();
    logic [4:0] codes[10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h1c, 5'h1d, 5'h1e};
    wr(CK, 8'h7a);
    rd(CK);
    chk("clock cfg", rdat, 32'h7a);
    foreach (codes[i]) begin
      wr(SC, {3'h0, codes[i]});
      waitFlag();
      chk("mux", channelSelect, codes[i]);
      chk("pins", pinAnalogSel, (codes[i] < 5'h06) ? (6'h01 << codes[i]) : 6'h00);
      rd(RS);
      chk("result", rdat, expRes(codes[i]));
      rd(SC);
      chk("flag clear", rdat, codes[i]);
    end
  endtask
  task automatic tIrq();
    int n;
    wr(SC, 8'h42);
    waitReq(n);
    chk("cpu req", {cpuIrq, dmaReq}, 2'h2);
    rd(SC);
    chk("route bit", rdat, 32'h42);
    rd(RS);
    repeat (3) @(posedge mclk);
    chk("cpu drop", cpuIrq, 1'b0);
    wr(SC, 8'hc2);  // dma route set on purpose though no dma exists
    rd(SC);
    chk("route written", rdat, 32'hc2);
    waitReq(n);
    chk("dma req", {cpuIrq, dmaReq}, 2'h1);
    rd(SC);
    chk("route bit", rdat, 32'hc2);
    wr(SC, 8'h1f);
    repeat (3) @(posedge mclk);
    chk("dma drop", dmaReq, 1'b0);
  endtask
  task automatic tCont();
    logic [7:0] e;
    wr(SC, 8'h23);
    waitFlag();
    rd(RS);
    chk("first", rdat, expRes(5'h03));
    levelShift <= 8'h08;
    repeat (300) @(posedge mclk);
    rd(SC);
    chk("flag once", rdat, 32'h23);
    rd(RS);
    chk("overwrite", rdat, expRes(5'h03));
    wr(SC, 8'h03);
    waitFlag();
    e = expRes(5'h03);
    levelShift <= 8'h00;
    repeat (300) @(posedge mclk);
    rd(RS);
    chk("single", rdat, e);
  endtask
  // a write mid conversion must give the new channel's code
  task automatic tRestart();
    wr(SC, 8'h00);
    repeat (60) @(posedge mclk);
    wr(SC, 8'h05);
    waitFlag();
    rd(RS);
    chk("restart", rdat, expRes(5'h05));
  endtask
  task automatic tStop();
    wr(SC, 8'h04);
    repeat (40) @(posedge mclk);
    stopMode <= 1'b1;
    repeat (200) @(posedge mclk);
    chk("stop power", adcPowerOn, 1'b0);
    rd(SC);
    chk("aborted", rdat, 32'h04);
    stopMode <= 1'b0;
    waitFlag();
    rd(RS);
    chk("resumed", rdat, expRes(5'h04));
  endtask
  // oscillator source, time to request per prescale code
  task automatic tPrescale();
    logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int n;
    int dv;
    foreach (codes[i]) begin
      dv = codes[i][2] ? 16 : (1 << codes[i]);
      wr(CK, {codes[i], 5'h00});
      wr(SC, 8'h41);
      waitReq(n);
      chk("divide", n >= dv * 15 * 45 / 8 && n <= dv * 90 + 16, 1'b1);
      rd(RS);
    end
    wr(SC, 8'h1f);
  endtask
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stopMode = 1'b0;
    levelShift = 8'h00;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    tReset();
    tChannels();
    tIrq();
    tCont();
    tRestart();
    tStop();
    tPrescale();
    finishTest();
  end
endmodule
`default_nettype wire
